// File: nchar_pkg.sv
// package: symbol codes, character kinds and word layout for the n-char word mapper
// assumes: 8-bit symbols with a control flag, four symbols to a word
package nchar_pkg;
  localparam int unsigned SYMS_PER_WORD = 4;                // characters in one link word
  localparam int unsigned SYM_W         = 8;                // bits in one symbol
  localparam logic [7:0]  K_ERROR       = 8'h00;            // k0.0 error symbol
  localparam logic [7:0]  K_EEP         = 8'h1C;            // k28.0 error end of packet
  localparam logic [7:0]  K_EOP         = 8'h5C;            // k28.2 end of packet
  localparam logic [7:0]  K_NULL        = 8'hF7;            // k23.7 pad null
  localparam logic [1:0]  FILL_RESET    = 2'h0;             // symbols gathered after reset

  // character kind as seen by the virtual channel buffers
  typedef enum logic [1:0] {
    CH_DATA = 2'b00,
    CH_EOP  = 2'b01,
    CH_EEP  = 2'b11,
    CH_NULL = 2'b10
  } char_kind_e;

  // one symbol: byte plus control flag
  typedef struct packed {
    logic       is_k;
    logic [7:0] code;
  } sym_s;

  // packer states, two only: fill, then pad
  typedef enum logic [1:0] {
    ST_FILL = 2'b00,
    ST_PAD  = 2'b01
  } pack_state_e;
endpackage

// File: word_stream_if.sv
// interface: a valid/ready stream of four-symbol words between the mapper's parts
// assumes: single clock, word taken when valid and ready are both high
`timescale 1ns/10ps
interface word_stream_if;
  import nchar_pkg::*;
  logic       valid;  // word on data is offered
  logic       ready;  // sink takes the word
  logic [35:0] data;  // four symbols, lowest first on the link
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// File: word_skid_buffer.sv
// two-entry buffer for words; keeps a stalled word instead of dropping it
// assumes: one clock, synchronous active-high reset
`timescale 1ns/10ps
module word_skid_buffer
  import nchar_pkg::*;
#(
  parameter int unsigned WIDTH = 36,
  parameter int unsigned DEPTH = 2
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  word_stream_if.snk in_s,
  word_stream_if.src out_s
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];  // flip-flop storage
  logic [AW-1:0]    wr_reg, wr_next;  // write index
  logic [AW-1:0]    rd_reg, rd_next;  // read index
  logic [AW:0]      cnt_reg, cnt_next; // occupancy
  logic             push, pop;

  // flags come straight from the occupancy count so full and empty stay honest
  assign in_s.ready  = (cnt_reg != (AW+1)'(DEPTH));  // full only at DEPTH entries
  assign out_s.valid = (cnt_reg != '0);
  assign out_s.data  = mem_reg[rd_reg];
  assign push = in_s.valid & in_s.ready;
  assign pop  = out_s.valid & out_s.ready;

  // next pointers and count
  always_comb begin
    wr_next  = push ? ((wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1) : wr_reg;
    rd_next  = pop  ? ((rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1) : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  // register state; storage needs no reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end else begin
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
    if (push) begin
      mem_reg[wr_reg] <= in_s.data;
    end
  end
endmodule // word_skid_buffer

// File: rx_word_mapper.sv
// receive side: passes decoded words on, substituting error words where needed
// assumes: the decoder flags per-symbol errors; one clock
`timescale 1ns/10ps
module rx_word_mapper
  import nchar_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        valid_i,    // decoded word present
  input  wire logic [35:0] word_i,     // four symbols, {is_k,code} each
  input  wire logic [3:0]  sym_err_i,  // per-symbol decode error
  input  wire logic        sync_ok_i,  // sync state machine ready
  word_stream_if.src       out_s
);
  logic [35:0] word_reg, word_next;   // held output word
  logic        vld_reg, vld_next;     // output valid

  // error symbol repeated four times forms the receive error word
  localparam logic [35:0] ERR_WORD = {4{1'b1, K_ERROR}};

  // substitute the error word, then hold until the unpacker accepts
  always_comb begin
    word_next = word_reg;
    vld_next  = vld_reg & ~out_s.ready;
    if (valid_i && (!vld_reg || out_s.ready)) begin
      vld_next = 1'b1;
      if (!sync_ok_i || (sym_err_i != 4'h0)) begin
        word_next = ERR_WORD;
      end else begin
        word_next = word_i;    // nulls and markers pass untouched
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_reg <= '0;
      vld_reg  <= 1'b0;
    end else begin
      word_reg <= word_next;
      vld_reg  <= vld_next;
    end
  end

  assign out_s.valid = vld_reg;
  assign out_s.data  = word_reg;
endmodule // rx_word_mapper

// File: nchar_word_symbol_mapper.sv
// top: maps characters to four-symbol words for transmit, and words back to characters
// assumes: one 100 MHz clock, synchronous reset, decoder and encoder outside this block
`timescale 1ns/10ps
module nchar_word_symbol_mapper
  import nchar_pkg::*;
(
  input  wire logic        MCLK_I,
  input  wire logic        RST_I,
  // transmit characters from the output virtual_channel_buffer
  input  wire logic        TX_CHAR_VALID_I,  // character offered
  input  wire logic [1:0]  TX_CHAR_KIND_I,   // data, eop, eep, null
  input  wire logic [7:0]  TX_CHAR_DATA_I,   // data byte
  input  wire logic        TX_FLUSH_I,       // no more characters now: pad the word
  output logic             TX_CHAR_READY_O,  // character taken
  // transmit words to the encoder
  output logic             TX_WORD_VALID_O,
  output logic [35:0]      TX_WORD_O,        // symbol 0 in bits 8:0 goes first
  input  wire logic        TX_WORD_READY_I,
  // receive words from the decoder
  input  wire logic        RX_WORD_VALID_I,
  input  wire logic [35:0] RX_WORD_I,
  input  wire logic [3:0]  RX_SYM_ERR_I,     // per-symbol decode error
  input  wire logic        RX_SYNC_READY_I,  // sync state machine in ready
  // receive characters to the input virtual_channel_buffer
  output logic             RX_CHAR_VALID_O,
  output logic [1:0]       RX_CHAR_KIND_O,
  output logic [7:0]       RX_CHAR_DATA_O,
  output logic             RX_CHAR_ERR_O,    // character came from an error word
  input  wire logic        RX_CHAR_READY_I
);
  word_stream_if tx_pack_s ();  // packer to buffer
  word_stream_if tx_buf_s ();   // buffer to output stage
  word_stream_if rx_map_s ();   // receive mapper to unpacker

  // transmit packing state
  pack_state_e  state_reg, state_next;
  logic [1:0]   fill_reg, fill_next;     // symbols gathered in this word
  sym_s [3:0]   acc_reg, acc_next;       // word under construction
  logic         take;
  sym_s         enc_sym;                 // encoded incoming character

  // transmit output stage
  logic         txv_reg, txv_next;
  logic [35:0]  txw_reg, txw_next;

  // receive unpacking
  logic [1:0]   rsel_reg, rsel_next;     // next symbol to hand out
  logic         rxv_reg, rxv_next;
  logic [1:0]   rxk_reg, rxk_next;
  logic [7:0]   rxd_reg, rxd_next;
  logic         rxe_reg, rxe_next;
  sym_s         rx_sym;
  logic         rx_take;

  // character to symbol; only the four legal kinds (data, eop, eep, null) are produced, never k0.0
  always_comb begin
    enc_sym = '{is_k: 1'b0, code: TX_CHAR_DATA_I};
    case (char_kind_e'(TX_CHAR_KIND_I))
      CH_EOP:  enc_sym = '{is_k: 1'b1, code: K_EOP};
      CH_EEP:  enc_sym = '{is_k: 1'b1, code: K_EEP};
      CH_NULL: enc_sym = '{is_k: 1'b1, code: K_NULL}; // caller nulls pass through
      default: enc_sym = '{is_k: 1'b0, code: TX_CHAR_DATA_I};
    endcase
  end

  // packer takes characters only while gathering and the buffer has room
  assign take            = (state_reg == ST_FILL) && TX_CHAR_VALID_I && tx_pack_s.ready;
  assign tx_pack_s.valid = (state_reg == ST_PAD) ||
                           (take && fill_reg == 2'd3);
  assign tx_pack_s.data  = (state_reg == ST_PAD) ? acc_reg :
                           {enc_sym, acc_reg[2:0]};

  // gather four characters; on an end marker or flush pad with one to three nulls
  always_comb begin
    state_next = state_reg;
    fill_next  = fill_reg;
    acc_next   = acc_reg;
    case (state_reg)
      ST_FILL: begin
        if (take) begin
          acc_next[fill_reg] = enc_sym;               // lowest slot first
          fill_next          = fill_reg + 2'd1;       // wraps after four
          // an end marker short of a full word closes it at once
          if (fill_reg != 2'd3 && enc_sym.is_k && enc_sym.code != K_NULL) begin
            state_next = ST_PAD;
            for (int i = 0; i < SYMS_PER_WORD; i++) begin
              if (i > fill_reg) acc_next[i] = '{is_k: 1'b1, code: K_NULL};
            end
          end
        end else if (TX_FLUSH_I && !TX_CHAR_VALID_I && fill_reg != FILL_RESET) begin
          state_next = ST_PAD;                       // a partial word never waits forever
          for (int i = 0; i < SYMS_PER_WORD; i++) begin
            if (i >= fill_reg) acc_next[i] = '{is_k: 1'b1, code: K_NULL};
          end
        end
      end
      ST_PAD: begin
        if (tx_pack_s.ready) begin
          state_next = ST_FILL;
          fill_next  = FILL_RESET;
        end
      end
      default: state_next = ST_FILL;
    endcase
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      state_reg <= ST_FILL;
      fill_reg  <= FILL_RESET;
      acc_reg   <= '0;
    end else begin
      state_reg <= state_next;
      fill_reg  <= fill_next;
      acc_reg   <= acc_next;
    end
  end

  // two-entry buffer so an encoder stall loses no word
  word_skid_buffer #(.WIDTH(36), .DEPTH(2)) u_tx_buf (
    .clk_i (MCLK_I),
    .rst_i (RST_I),
    .in_s  (tx_pack_s),
    .out_s (tx_buf_s)
  );

  // output register keeps the word on a flop until the encoder takes it
  assign tx_buf_s.ready = !txv_reg || TX_WORD_READY_I;
  always_comb begin
    txv_next = txv_reg;
    txw_next = txw_reg;
    if (tx_buf_s.ready) begin
      txv_next = tx_buf_s.valid;
      if (tx_buf_s.valid) txw_next = tx_buf_s.data;
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      txv_reg <= 1'b0;
      txw_reg <= '0;
    end else begin
      txv_reg <= txv_next;
      txw_reg <= txw_next;
    end
  end

  // receive error substitution
  rx_word_mapper u_rx_map (
    .clk_i     (MCLK_I),
    .rst_i     (RST_I),
    .valid_i   (RX_WORD_VALID_I),
    .word_i    (RX_WORD_I),
    .sym_err_i (RX_SYM_ERR_I),
    .sync_ok_i (RX_SYNC_READY_I),
    .out_s     (rx_map_s)
  );

  // unpack one symbol per cycle, lowest first; the word is released after the fourth
  assign rx_sym         = rx_map_s.data[rsel_reg*9 +: 9];
  assign rx_take        = rx_map_s.valid && (!rxv_reg || RX_CHAR_READY_I);
  assign rx_map_s.ready = rx_take && (rsel_reg == 2'd3);

  // symbol to character; markers and nulls are legal in any slot
  always_comb begin
    rsel_next = rsel_reg;
    rxv_next  = rxv_reg & ~RX_CHAR_READY_I;
    rxk_next  = rxk_reg;
    rxd_next  = rxd_reg;
    rxe_next  = rxe_reg;
    if (rx_take) begin
      rsel_next = rsel_reg + 2'd1;
      rxv_next  = 1'b1;
      rxd_next  = rx_sym.code;
      rxe_next  = 1'b0;
      if (!rx_sym.is_k) begin
        rxk_next = CH_DATA;                             // any symbol without the control flag is a data character
      end else begin
        case (rx_sym.code)
          K_EOP:   rxk_next = CH_EOP;
          K_EEP:   rxk_next = CH_EEP;
          K_NULL:  rxk_next = CH_NULL;
          default: begin
            rxk_next = CH_NULL;                         // error symbol: flag it
            rxe_next = 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RST_I) begin
      rsel_reg <= '0;
      rxv_reg  <= 1'b0;
      rxk_reg  <= CH_DATA;
      rxd_reg  <= '0;
      rxe_reg  <= 1'b0;
    end else begin
      rsel_reg <= rsel_next;
      rxv_reg  <= rxv_next;
      rxk_reg  <= rxk_next;
      rxd_reg  <= rxd_next;
      rxe_reg  <= rxe_next;
    end
  end

  // ports driven from flops, except the character ready which is the packer's take
  assign TX_CHAR_READY_O = take;
  assign TX_WORD_VALID_O = txv_reg;
  assign TX_WORD_O       = txw_reg;
  assign RX_CHAR_VALID_O = rxv_reg;
  assign RX_CHAR_KIND_O  = rxk_reg;
  assign RX_CHAR_DATA_O  = rxd_reg;
  assign RX_CHAR_ERR_O   = rxe_reg;
endmodule // nchar_word_symbol_mapper

// File: nchar_mapper_sva.sv
// checker: port-level timing and value properties of the word mapper
// assumes: bound to the top module, one clock, reset active high
`timescale 1ns/10ps
module nchar_mapper_sva
  import nchar_pkg::*;
(
  input wire logic        MCLK_I,
  input wire logic        RST_I,
  input wire logic        TX_CHAR_VALID_I,
  input wire logic        TX_CHAR_READY_O,
  input wire logic        TX_WORD_VALID_O,
  input wire logic [35:0] TX_WORD_O,
  input wire logic        TX_WORD_READY_I,
  input wire logic        RX_WORD_VALID_I,
  input wire logic [35:0] RX_WORD_I,
  input wire logic [3:0]  RX_SYM_ERR_I,
  input wire logic        RX_SYNC_READY_I,
  input wire logic        RX_CHAR_VALID_O,
  input wire logic [1:0]  RX_CHAR_KIND_O,
  input wire logic [7:0]  RX_CHAR_DATA_O,
  input wire logic        RX_CHAR_ERR_O,
  input wire logic        RX_CHAR_READY_I
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (RST_I);
  logic pad_ok;   // an end marker is followed only by nulls
  logic err_sym;  // some slot holds the error symbol
  // word scan kept combinational so the properties stay short
  always_comb begin
    pad_ok  = 1'b1;
    err_sym = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (TX_WORD_O[9*i +: 9] == {1'b1, K_ERROR}) err_sym = 1'b1;
      for (int j = i + 1; j < 4; j++) begin
        if ((TX_WORD_O[9*i +: 9] == {1'b1, K_EOP} || TX_WORD_O[9*i +: 9] == {1'b1, K_EEP})
            && TX_WORD_O[9*j +: 9] != {1'b1, K_NULL}) pad_ok = 1'b0;
      end
    end
  end
  a_err_word_code: assert property (
    RX_CHAR_VALID_O && RX_CHAR_ERR_O |-> RX_CHAR_KIND_O == CH_NULL && RX_CHAR_DATA_O == 8'h00)
    else $error("error character has wrong kind or data");
  a_sync_lost_err: assert property (
    RX_WORD_VALID_I && !RX_SYNC_READY_I |-> ##2 RX_CHAR_VALID_O && RX_CHAR_ERR_O)
    else $error("word without sync not turned into error word");
  a_sym_err_word: assert property (
    RX_WORD_VALID_I && RX_SYM_ERR_I != 4'h0 |-> ##2 RX_CHAR_VALID_O && RX_CHAR_ERR_O)
    else $error("errored word not turned into error word");
  a_clean_word_pass: assert property (
    RX_WORD_VALID_I && RX_SYNC_READY_I && RX_SYM_ERR_I == 4'h0 |-> ##2 RX_CHAR_VALID_O && !RX_CHAR_ERR_O)
    else $error("clean word not delivered two cycles later");
  a_eop_decode: assert property (
    RX_WORD_VALID_I && RX_SYNC_READY_I && RX_SYM_ERR_I == 4'h0 && RX_WORD_I[8:0] == {1'b1, K_EOP}
    |-> ##2 RX_CHAR_KIND_O == CH_EOP)
    else $error("end of packet symbol decoded to wrong kind");
  a_no_err_sent: assert property (TX_WORD_VALID_O |-> !err_sym)
    else $error("error symbol offered for transmission");
  a_marker_pad: assert property (TX_WORD_VALID_O |-> pad_ok)
    else $error("end marker not followed by pad nulls");
  a_tx_word_hold: assert property (
    TX_WORD_VALID_O && !TX_WORD_READY_I |=> TX_WORD_VALID_O && $stable(TX_WORD_O))
    else $error("stalled transmit word changed or dropped");
  a_rx_char_hold: assert property (
    RX_CHAR_VALID_O && !RX_CHAR_READY_I |=> RX_CHAR_VALID_O
    && $stable({RX_CHAR_KIND_O, RX_CHAR_DATA_O, RX_CHAR_ERR_O}))
    else $error("stalled receive character changed or dropped");
  a_reset_quiet: assert property (disable iff (1'b0) RST_I |=> !TX_WORD_VALID_O && !RX_CHAR_VALID_O)
    else $error("valid output high after reset edge");
  c_tx_stall: cover property (TX_WORD_VALID_O && !TX_WORD_READY_I);
  c_char_refused: cover property (TX_CHAR_VALID_I && !TX_CHAR_READY_O);
  c_rx_err: cover property (RX_CHAR_VALID_O && RX_CHAR_ERR_O);
endmodule // nchar_mapper_sva
bind nchar_word_symbol_mapper nchar_mapper_sva nchar_mapper_sva_inst (
  .MCLK_I(MCLK_I), .RST_I(RST_I), .TX_CHAR_VALID_I(TX_CHAR_VALID_I),
  .TX_CHAR_READY_O(TX_CHAR_READY_O), .TX_WORD_VALID_O(TX_WORD_VALID_O), .TX_WORD_O(TX_WORD_O),
  .TX_WORD_READY_I(TX_WORD_READY_I), .RX_WORD_VALID_I(RX_WORD_VALID_I), .RX_WORD_I(RX_WORD_I),
  .RX_SYM_ERR_I(RX_SYM_ERR_I), .RX_SYNC_READY_I(RX_SYNC_READY_I),
  .RX_CHAR_VALID_O(RX_CHAR_VALID_O), .RX_CHAR_KIND_O(RX_CHAR_KIND_O),
  .RX_CHAR_DATA_O(RX_CHAR_DATA_O), .RX_CHAR_ERR_O(RX_CHAR_ERR_O),
  .RX_CHAR_READY_I(RX_CHAR_READY_I));

// File: link_far_end.sv
// partner: encoder and decoder side of the mapper
// assumes: the bench calls send_word just after a rising edge
`timescale 1ns/10ps
module link_far_end (
  input  wire logic        clk_i,
  input  wire logic        slow_i,        // stall the encoder port
  input  wire logic        word_valid_i,
  input  wire logic [35:0] word_i,
  output logic             word_ready_o,
  output logic             rx_valid_o,
  output logic [35:0]      rx_word_o,
  output logic [3:0]       rx_err_o,
  output logic             rx_sync_o
);
  logic [35:0] got[$];         // words taken from the encoder port
  logic [2:0]  cnt_reg = 3'h0; // stall phase counter
  initial begin
    rx_valid_o = 1'b0;
    rx_word_o  = 36'h0;
    rx_err_o   = 4'h0;
    rx_sync_o  = 1'b1;
  end
  // slow mode refuses half the cycles so the buffer fills
  assign word_ready_o = !slow_i || cnt_reg < 3'h4;
  // collect whole words, symbol 0 in the low bits
  always @(posedge clk_i) begin
    cnt_reg <= cnt_reg + 3'h1;
    if (word_valid_i && word_ready_o) got.push_back(word_i);
  end
  // one decoded word for one cycle; data lines then show garbage
  task send_word(input logic [35:0] w, input logic [3:0] e, input logic s);
    rx_valid_o <= 1'b1;
    rx_word_o  <= w;
    rx_err_o   <= e;
    rx_sync_o  <= s;
    @(posedge clk_i);
    rx_valid_o <= 1'b0;
    rx_word_o  <= ~w;
    rx_err_o   <= ~e;
  endtask
endmodule // link_far_end

// File: tb_top.sv
// testbench: random packets out and random words in, checked against expectation
// assumes: package, design, checker and partner compiled first
`timescale 1ns/10ps
module tb_top;
  import nchar_pkg::*;
  logic        mclk = 1'b0, rst = 1'b1, tx_valid = 1'b0, tx_flush = 1'b0;
  logic [1:0]  tx_kind = 2'h0, rc_kind;
  logic [7:0]  tx_data = 8'h00, rc_data;
  logic        tx_ready, tw_valid, tw_ready, rw_valid, rw_sync, rc_valid, rc_err;
  logic        rc_ready = 1'b0, slow = 1'b0;
  logic [35:0] tw_data, rw_data;
  logic [3:0]  rw_err;
  logic [31:0] seed = 32'h0000_ed58;  // fixed seed, repeatable run
  logic [8:0]  exp_q[$];              // expected transmit symbols
  logic [10:0] rx_exp[$], rx_got[$];  // received chars {kind,data,err}
  int          errors = 0, checks_done = 0, nfill = 0, cyc = 0;
  always #5 mclk = ~mclk;
  nchar_word_symbol_mapper nchar_word_symbol_mapper_inst (
    .MCLK_I(mclk), .RST_I(rst), .TX_CHAR_VALID_I(tx_valid), .TX_CHAR_KIND_I(tx_kind),
    .TX_CHAR_DATA_I(tx_data), .TX_FLUSH_I(tx_flush), .TX_CHAR_READY_O(tx_ready),
    .TX_WORD_VALID_O(tw_valid), .TX_WORD_O(tw_data), .TX_WORD_READY_I(tw_ready),
    .RX_WORD_VALID_I(rw_valid), .RX_WORD_I(rw_data), .RX_SYM_ERR_I(rw_err),
    .RX_SYNC_READY_I(rw_sync), .RX_CHAR_VALID_O(rc_valid), .RX_CHAR_KIND_O(rc_kind),
    .RX_CHAR_DATA_O(rc_data), .RX_CHAR_ERR_O(rc_err), .RX_CHAR_READY_I(rc_ready));
  link_far_end link_far_end_inst (
    .clk_i(mclk), .slow_i(slow), .word_valid_i(tw_valid), .word_i(tw_data),
    .word_ready_o(tw_ready), .rx_valid_o(rw_valid), .rx_word_o(rw_data),
    .rx_err_o(rw_err), .rx_sync_o(rw_sync));
  function automatic logic [31:0] rnd();
    repeat (16) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [8:0] sym_of(input logic [1:0] k, input logic [7:0] d);
    case (k)
      CH_EOP:  return {1'b1, K_EOP};
      CH_EEP:  return {1'b1, K_EEP};
      CH_NULL: return {1'b1, K_NULL};
      default: return {1'b0, d};
    endcase
  endfunction
  function automatic logic [10:0] rx_of(input logic [8:0] s, input logic bad);
    logic [1:0] k;
    k = CH_DATA;
    if (bad) return {CH_NULL, 8'h00, 1'b1};
    if (s == {1'b1, K_EOP}) k = CH_EOP;
    if (s == {1'b1, K_EEP}) k = CH_EEP;
    if (s == {1'b1, K_NULL}) k = CH_NULL;
    return {k, (k == CH_DATA) ? s[7:0] : 8'h00, 1'b0};
  endfunction
  // data byte only matters for data and error characters
  function automatic logic [10:0] mask(input logic [10:0] x);
    return {x[10:9], (x[10:9] == CH_DATA || x[0]) ? x[8:1] : 8'h00, x[0]};
  endfunction
  task check(input string name, input logic [35:0] seen, input logic [35:0] expv);
    checks_done++;
    if (seen !== expv) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, expv, seen);
    end
  endtask
  task close_out();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task give_up();
    errors++;
    close_out();
  endtask
  task pad();
    while (nfill != 0) begin
      exp_q.push_back({1'b1, K_NULL});
      nfill = (nfill + 1) % 4;
    end
  endtask
  // offer one character and hold it until the edge that takes it
  task tx_char(input logic [1:0] k, input logic [7:0] d);
    int n;
    n = 0;
    tx_valid <= 1'b1;
    tx_kind  <= k;
    tx_data  <= d;
    exp_q.push_back(sym_of(k, d));
    nfill = (nfill + 1) % 4;
    @(posedge mclk);
    while (tx_ready !== 1'b1) begin
      if (++n > 400) give_up();
      @(posedge mclk);
    end
    if (k == CH_EOP || k == CH_EEP) pad();
  endtask
  task wait_tx();
    int n;
    n = 0;
    while (link_far_end_inst.got.size() * 4 != exp_q.size()) begin
      if (++n > 2000) give_up();
      @(posedge mclk);
    end
  endtask
  // send one word, then wait until all four characters are out
  task rx_word(input logic [35:0] w, input logic [3:0] e, input logic s);
    int n;
    n = 0;
    // one bad symbol spoils the whole word
    for (int i = 0; i < 4; i++)
      rx_exp.push_back(rx_of(w[9*i +: 9], (e != 4'h0) | !s));
    link_far_end_inst.send_word(w, e, s);
    while (rx_got.size() != rx_exp.size()) begin
      if (++n > 400) give_up();
      @(posedge mclk);
    end
    repeat (2) @(posedge mclk);
  endtask
  // receive sink stalls one cycle in three
  always @(posedge mclk) begin
    cyc++;
    rc_ready <= (cyc % 3) != 0;
    if (rc_valid === 1'b1 && rc_ready === 1'b1) rx_got.push_back({rc_kind, rc_data, rc_err});
  end
  initial begin
    #900000;
    give_up();
  end
  initial begin
    logic [31:0] r;
    logic [35:0] w;
    int n;
    repeat (3) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    check("reset_valids", {34'h0, tw_valid, rc_valid}, 36'h0);
    for (int p = 0; p < 30; p++) begin
      r = rnd();
      slow <= r[8];
      n = r[2:0] % 6;
      // a caller null now and then checks pass-through of the null kind
      for (int i = 0; i < n; i++)
        tx_char((p % 3 == 1 && i == 1) ? CH_NULL : CH_DATA,
                (p == 0) ? {8{i[0]}} : 8'(rnd()));
      if (p % 5 == 4) begin
        tx_valid <= 1'b0;
        tx_flush <= 1'b1;
        pad();
        wait_tx();
        @(posedge mclk);
        tx_flush <= 1'b0;
      end else tx_char(r[9] ? CH_EOP : CH_EEP, 8'h00);
    end
    tx_valid <= 1'b0;
    slow <= 1'b0;
    wait_tx();
    for (int i = 0; i < link_far_end_inst.got.size(); i++) begin
      for (int j = 0; j < 4; j++) w[9*j +: 9] = exp_q[4*i + j];
      check("tx_word", link_far_end_inst.got[i], w);
    end
    for (int k = 0; k < 40; k++) begin
      for (int i = 0; i < 4; i++) begin
        r = rnd();
        w[9*i +: 9] = sym_of(r[1:0], r[15:8]);
      end
      rx_word(w, (k == 0) ? 4'hf : ((r[20:18] == 3'h0) ? 4'h1 << r[17:16] : 4'h0),
              (k != 1) && (r[23:21] != 3'h0));
    end
    for (int i = 0; i < rx_exp.size(); i++)
      check("rx_char", {25'h0, mask(rx_got[i])}, {25'h0, rx_exp[i]});
    close_out();
  end
endmodule // tb_top
